// file: digital_io_channel_supervisor.sv
// digital i/o channel supervisor: filtering, stretching, fault outputs, supervision, counters
`timescale 1ns/1ps
// What this block does
// - flag supply short when supervision enabled
// - mask overcurrent 100 ms after inrush
// - reject input changes shorter than filter time
// - hold detected input for stretch time
// - flag load short when supervision enabled
// - auto restart clears error when short clears
// - manual restart latches error until power-up or until load short supervision is disabled
// - flag open load per channel when enabled
// - fault action per channel: clear, hold, force
// - fault action only when handheld priority selected
// - count ON operations, error above limit
// - limit compared multiplied by one thousand
// - save counts to retained storage hourly
// - resume counts from saved values after power-up

`include "dio_supervisor_regs.svh"

module digital_io_channel_supervisor #(
  parameter int          N_IN          = 8,
  parameter int          N_OUT         = 8,
  parameter int          CW            = 32,
  parameter logic [31:0] INRUSH_US     = `INRUSH_MASK_US,
  parameter logic [31:0] SAVE_US       = `SAVE_PERIOD_US
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [N_IN-1:0]           in_pin,
  input  wire logic [1:0]                input_filter_time_sel,
  input  wire logic [1:0]                input_stretch_time_sel,
  output logic      [N_IN-1:0]           in_state,
  input  wire logic                      supply_short_pin,
  input  wire logic                      supply_short_supervise_en,
  output logic                           supply_short_err,
  input  wire logic                      inrush_pin,
  input  wire logic                      inrush_mask_en,
  input  wire logic [N_OUT-1:0]          overcurrent_pin,
  input  wire logic                      load_short_supervise_en,
  input  wire logic                      load_short_restart_mode,
  output logic                           load_short_err,
  input  wire logic [N_OUT-1:0]          open_load_pin,
  input  wire logic                      open_load_supervise_en,
  output logic      [N_OUT-1:0]          open_load_err,
  input  wire logic [N_OUT-1:0]          out_cmd,
  input  wire logic                      comm_fault,
  input  wire logic                      handheld_priority,
  input  wire logic [2*N_OUT-1:0]        comm_fault_output_action,
  output logic      [N_OUT-1:0]          out_drive,
  input  wire logic                      count_en,
  input  wire logic [15:0]               count_limit,
  output logic      [N_IN+N_OUT-1:0]     count_err,
  input  wire logic [(N_IN+N_OUT)*CW-1:0] saved_count,
  output logic                           save_strobe,
  output logic      [(N_IN+N_OUT)*CW-1:0] count_value
);
  localparam int NCH = N_IN + N_OUT;

  // ****************************************
  // microsecond tick prescaler
  // ****************************************
  localparam logic [7:0] TICK_LAST = 8'(`TICK_CYCLES - 1);
  logic [7:0]  pre_reg;
  logic        tick;
  assign tick = (pre_reg == TICK_LAST);

  // one tick per microsecond keeps every interval counter narrow
  // an 8-bit prescaler limits the clock to 256 MHz
  always_ff @(posedge clk) begin
    if (rst || tick) pre_reg <= 8'h00;
    else pre_reg <= pre_reg + 8'h01;
  end

  // selector codes map to interval lengths in ticks
  function automatic logic [17:0] filt_us(input logic [1:0] s);
    case (s)
      2'h0:    filt_us = 18'(`FILT_T0_US);
      2'h1:    filt_us = 18'(`FILT_T1_US);
      2'h2:    filt_us = 18'(`FILT_T2_US);
      default: filt_us = 18'(`FILT_T3_US);
    endcase
  endfunction

  function automatic logic [17:0] stretch_us(input logic [1:0] s);
    case (s)
      2'h0:    stretch_us = 18'(`STRETCH_T0_US);
      2'h1:    stretch_us = 18'(`STRETCH_T1_US);
      2'h2:    stretch_us = 18'(`STRETCH_T2_US);
      default: stretch_us = 18'(`STRETCH_T3_US);
    endcase
  endfunction
  wire logic [17:0] filt_lim    = filt_us(input_filter_time_sel);
  wire logic [17:0] stretch_lim = stretch_us(input_stretch_time_sel);

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int SW = N_IN + 3 + 2*N_OUT;
  logic [SW-1:0] s1_reg, s2_reg;
  always_ff @(posedge clk) begin
    s1_reg <= {in_pin, supply_short_pin, inrush_pin, comm_fault,
               overcurrent_pin, open_load_pin};
    s2_reg <= s1_reg;
  end

  // settings and out_cmd come from logic on this clock and skip the stage
  wire logic [N_IN-1:0]  in_s   = s2_reg[SW-1 -: N_IN];
  wire logic             sup_s  = s2_reg[2*N_OUT+2];
  wire logic             inr_s  = s2_reg[2*N_OUT+1];
  wire logic             cf_s   = s2_reg[2*N_OUT];
  wire logic [N_OUT-1:0] oc_s   = s2_reg[2*N_OUT-1 -: N_OUT];
  wire logic [N_OUT-1:0] ol_s   = s2_reg[N_OUT-1:0];

  // ****************************************
  // input filter and stretch per channel
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : g_in
      logic        filt_reg;
      logic [17:0] fcnt_reg;
      logic        out_reg;
      logic [17:0] hcnt_reg;
      // a change must persist the whole filter time before acceptance
      always_ff @(posedge clk) begin
        if (rst) begin
          filt_reg <= 1'b0;
          fcnt_reg <= 18'h00000;
        end else if (in_s[g] == filt_reg) begin
          fcnt_reg <= 18'h00000;
        end else if (tick) begin
          if (fcnt_reg + 18'h00001 >= filt_lim) begin
            filt_reg <= in_s[g];
            fcnt_reg <= 18'h00000;
          end else fcnt_reg <= fcnt_reg + 18'h00001;
        end
      end

      // every accepted state stands at least the stretch time
      // a newer change waits until the hold has run out
      always_ff @(posedge clk) begin
        if (rst) begin
          out_reg  <= 1'b0;
          hcnt_reg <= 18'h00000;
        end else if (hcnt_reg != 18'h00000) begin
          if (tick) hcnt_reg <= hcnt_reg - 18'h00001;
        end else if (filt_reg != out_reg) begin
          out_reg  <= filt_reg;
          hcnt_reg <= stretch_lim;
        end
      end

      assign in_state[g] = out_reg;
    end
  endgenerate

  // ****************************************
  // supply short and inrush masking
  // ****************************************
  logic        sup_err_reg;
  logic [17:0] inr_cnt_reg;
  logic        inr_prev_reg;
  wire logic   inr_edge = inr_s && !inr_prev_reg;

  always_ff @(posedge clk) begin
    if (rst) sup_err_reg <= 1'b0;
    else sup_err_reg <= supply_short_supervise_en & sup_s;
  end
  assign supply_short_err = sup_err_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      inr_cnt_reg  <= 18'h00000;
      inr_prev_reg <= 1'b0;
    end else begin
      inr_prev_reg <= inr_s;
      if (inr_edge && inrush_mask_en) inr_cnt_reg <= INRUSH_US[17:0];
      else if (tick && inr_cnt_reg != 18'h00000) inr_cnt_reg <= inr_cnt_reg - 18'h00001;
    end
  end
  // overcurrent and inrush leave the synchroniser together, so the
  // edge cycle itself is masked as well; a disabled mask never delays a short
  wire logic oc_masked = inrush_mask_en && (inr_edge || inr_cnt_reg != 18'h00000);

  // ****************************************
  // load short and open load
  // ****************************************
  logic             ls_err_reg;
  logic [N_OUT-1:0] ol_err_reg;
  logic             ls_err_next;
  wire logic short_now = load_short_supervise_en && !oc_masked && (|oc_s);

  // a short in the same cycle as a clear wins
  // manual mode only leaves the latch at reset, i.e. power-up, or when load_short_supervise_en is cleared
  assign ls_err_next = short_now ? 1'b1 :
                       !load_short_supervise_en ? 1'b0 :
                       !load_short_restart_mode ? 1'b0 :
                       ls_err_reg;
  always_ff @(posedge clk) begin
    if (rst) ls_err_reg <= 1'b0;
    else ls_err_reg <= ls_err_next;
  end
  assign load_short_err = ls_err_reg;

  // open load follows the pin with no latch
  always_ff @(posedge clk) begin
    if (rst) ol_err_reg <= '0;
    else ol_err_reg <= open_load_supervise_en ? ol_s : '0;
  end
  assign open_load_err = ol_err_reg;

  // ****************************************
  // fault output selection
  // ****************************************
  logic [N_OUT-1:0] drive_reg;
  logic [N_OUT-1:0] drive_next;
  generate
    for (g = 0; g < N_OUT; g++) begin : g_out
      wire logic [1:0] act = comm_fault_output_action[2*g +: 2];
      wire logic drive_high_on_fault = (act == dio_supervisor_pkg::FAULT_FORCE);
      wire logic hold_sel = (act == dio_supervisor_pkg::FAULT_HOLD);
      // without handheld priority, fault turns outputs off
      // hold reads the registered output, not the live command
      assign drive_next[g] = !cf_s ? out_cmd[g] :
                             !handheld_priority ? 1'b0 :
                             drive_high_on_fault ? 1'b1 :
                             hold_sel ? drive_reg[g] : 1'b0;
    end
  endgenerate

  // one register per output keeps the hold path glitch-free
  always_ff @(posedge clk) begin
    if (rst) drive_reg <= '0;
    else drive_reg <= drive_next;
  end
  assign out_drive = drive_reg;

  // ****************************************
  // ON counters, hourly save, resume
  // ****************************************
  // outputs low, inputs high in every per-channel vector
  wire logic [NCH-1:0] ch_on = {in_state, drive_reg};
  logic [NCH-1:0] on_prev_reg;
  logic           loaded_reg;
  logic [31:0]    save_cnt_reg;
  logic           save_reg;
  wire logic [CW-1:0] limit_scaled = CW'(count_limit) * CW'(`COUNT_SCALE);
  // a limit outside 1 to 65000 switches the error off
  wire logic          limit_ok = (count_limit != 16'h0000) && (count_limit <= 16'(`LIMIT_MAX));

  generate
    for (g = 0; g < NCH; g++) begin : g_cnt
      logic [CW-1:0] c_reg;
      logic          err_reg;
      // the first edge after reset reloads the retained value, so a
      // count resumes where the last save left it
      always_ff @(posedge clk) begin
        if (rst) c_reg <= '0;
        else if (!loaded_reg) c_reg <= saved_count[g*CW +: CW];
        else if (ch_on[g] && !on_prev_reg[g]) c_reg <= c_reg + CW'(1);
      end
      always_ff @(posedge clk) begin
        if (rst) err_reg <= 1'b0;
        else err_reg <= count_en && limit_ok && loaded_reg
                               && (c_reg > limit_scaled);
      end
      assign count_value[g*CW +: CW] = c_reg;
      assign count_err[g] = err_reg;
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      on_prev_reg <= '0;
      loaded_reg  <= 1'b0;
    end else begin
      on_prev_reg <= ch_on;
      loaded_reg  <= 1'b1;
    end
  end
  // 32 bits of microseconds cover the hourly period
  // the strobe lasts one cycle; the store copies count_value then
  always_ff @(posedge clk) begin
    if (rst) begin
      save_cnt_reg <= 32'h00000000;
      save_reg     <= 1'b0;
    end else begin
      save_reg <= 1'b0;
      if (tick) begin
        if (save_cnt_reg + 32'h00000001 >= SAVE_US) begin
          save_cnt_reg <= 32'h00000000;
          save_reg     <= 1'b1;
        end else save_cnt_reg <= save_cnt_reg + 32'h00000001;
      end
    end
  end
  assign save_strobe = save_reg;
endmodule // digital_io_channel_supervisor

// file: digital_io_channel_supervisor_chk.sv
// port-level assertions for the digital i/o channel supervisor
`timescale 1ns/1ps
module digital_io_channel_supervisor_chk #(parameter int N_OUT = 8) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               supply_short_pin,
  input wire logic               supply_short_supervise_en,
  input wire logic               supply_short_err,
  input wire logic [N_OUT-1:0]   overcurrent_pin,
  input wire logic               load_short_restart_mode,
  input wire logic               load_short_err,
  input wire logic [N_OUT-1:0]   open_load_pin,
  input wire logic               open_load_supervise_en,
  input wire logic [N_OUT-1:0]   open_load_err,
  input wire logic               comm_fault,
  input wire logic               handheld_priority,
  input wire logic [2*N_OUT-1:0] comm_fault_output_action,
  input wire logic [N_OUT-1:0]   out_drive,
  input wire logic               save_strobe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // repetitions of 4 or 5 cover the 3-cycle synchroniser latency
  wire logic [1:0] act0 = comm_fault_output_action[1:0];
  wire logic       hh_fault = comm_fault && handheld_priority;
  a_supply_flag: assert property (
    (supply_short_pin && supply_short_supervise_en)[*4] |=> supply_short_err)
    else $error("supply short not flagged");
  a_supply_quiet: assert property (
    (!supply_short_supervise_en)[*4] |=> !supply_short_err)
    else $error("supply short flagged while disabled");
  a_open_flag: assert property (
    (open_load_pin[0] && open_load_supervise_en)[*4] |=> open_load_err[0])
    else $error("open load not flagged");
  a_short_autoclear: assert property (
    (!load_short_restart_mode && overcurrent_pin == '0)[*5] |=> !load_short_err)
    else $error("load short not cleared in auto mode");
  a_short_latch: assert property (
    load_short_err && load_short_restart_mode ##1 load_short_restart_mode |-> load_short_err)
    else $error("load short dropped in manual mode");
  a_fault_force: assert property (
    (hh_fault && act0 == 2'h2)[*5] |=> out_drive[0])
    else $error("forced output not on");
  a_fault_clear: assert property (
    (comm_fault && (!handheld_priority || act0 == 2'h0))[*5] |=> !out_drive[0])
    else $error("cleared output not off");
  a_fault_hold: assert property (
    (hh_fault && act0 == 2'h1)[*5] |=> $stable(out_drive[0]))
    else $error("held output changed");
  a_save_pulse: assert property (
    save_strobe |=> !save_strobe)
    else $error("save strobe longer than one cycle");
endmodule // digital_io_channel_supervisor_chk
bind digital_io_channel_supervisor digital_io_channel_supervisor_chk #(.N_OUT(N_OUT)) u_chk (
  .clk, .rst, .supply_short_pin, .supply_short_supervise_en, .supply_short_err,
  .overcurrent_pin, .load_short_restart_mode, .load_short_err, .open_load_pin,
  .open_load_supervise_en, .open_load_err, .comm_fault, .handheld_priority,
  .comm_fault_output_action, .out_drive, .save_strobe);

// file: dio_field_model.sv
// field side model: sensors, switched loads and supply faults
`timescale 1ns/1ps
module dio_field_model #(parameter int N_IN = 2, parameter int N_OUT = 2) (
  input  wire logic             clk,
  input  wire logic [N_IN-1:0]  sensor_on,
  input  wire logic             supply_fault,
  input  wire logic [N_OUT-1:0] load_shorted,
  input  wire logic [N_OUT-1:0] wire_cut,
  input  wire logic [N_OUT-1:0] out_drive,
  output logic      [N_IN-1:0]  in_pin,
  output logic                  supply_short_pin,
  output logic      [N_OUT-1:0] overcurrent_pin,
  output logic      [N_OUT-1:0] open_load_pin,
  output logic                  inrush_pin
);
  logic [N_OUT-1:0] drive_reg;
  always_ff @(posedge clk) begin
    drive_reg <= out_drive;
  end
  assign in_pin = sensor_on;
  assign supply_short_pin = supply_fault;
  // a shorted load only draws current while switched on
  assign overcurrent_pin = out_drive & load_shorted;
  assign open_load_pin = wire_cut;
  // every switch-on is an inrush, so a shorted load trips on switch-on unless masked
  assign inrush_pin = |(out_drive & ~drive_reg);
endmodule // dio_field_model

// file: dio_supervisor_pkg.sv
// types for the digital i/o channel supervisor
package dio_supervisor_pkg;
  typedef enum logic [1:0] {
    FAULT_CLEAR = 2'h0,
    FAULT_HOLD  = 2'h1,
    FAULT_FORCE = 2'h2
  } fault_action_t;
endpackage

// file: dio_supervisor_regs.svh
// timing constants and selector codes for the digital i/o channel supervisor
`ifndef DIO_SUPERVISOR_REGS_SVH
`define DIO_SUPERVISOR_REGS_SVH
`define CLK_HZ            32'h017D7840
`define TICK_US           32'h00000001
`define TICK_CYCLES       (`CLK_HZ / 32'h000F4240 * `TICK_US)
`define FILT_T0_US        32'h00000064
`define FILT_T1_US        32'h000003E8
`define FILT_T2_US        32'h00002710
`define FILT_T3_US        32'h00004E20
`define FILT_DEFAULT      2'h1
`define STRETCH_T0_US     32'h000003E8
`define STRETCH_T1_US     32'h00003A98
`define STRETCH_T2_US     32'h000186A0
`define STRETCH_T3_US     32'h00030D40
`define STRETCH_DEFAULT   2'h1
`define INRUSH_MASK_US    32'h000186A0
`define SAVE_PERIOD_US    32'hD693A400
`define COUNT_SCALE       32'h000003E8
`define LIMIT_MAX         32'h0000FDE8
`endif

// file: testbench.sv
// self-checking testbench for the digital i/o channel supervisor
`timescale 1ns/1ps
module testbench;
  typedef struct {int idx; logic [31:0] exp;} note_t;
  logic clk, rst, supply_fault, supply_short_supervise_en, inrush_mask_en, comm_fault, count_en;
  logic load_short_supervise_en, load_short_restart_mode, open_load_supervise_en;
  logic handheld_priority, save_strobe, supply_short_pin, supply_short_err, inrush_pin, e;
  logic [1:0] input_filter_time_sel, input_stretch_time_sel, sensor_on, load_shorted, wire_cut;
  logic [1:0] out_cmd, in_pin, in_state, overcurrent_pin, open_load_pin, open_load_err, out_drive;
  logic [3:0] comm_fault_output_action, count_err;
  logic [15:0] count_limit;
  logic [127:0] saved_count, count_value;
  logic load_short_err;
  string nm [8] = '{"count", "count_err", "supply_err", "load_err", "open_err", "drive",
                    "in_state", "save"};
  note_t notes [$];
  note_t nt;
  int errors = 0, n_tests = 0, cyc = 0, n, seed;
  event go;
  function automatic logic [31:0] obs(input int idx);
    case (idx)
      0:       obs = count_value[31:0];
      1:       obs = {31'h0, count_err[0]};
      2:       obs = {31'h0, supply_short_err};
      3:       obs = {31'h0, load_short_err};
      4:       obs = {31'h0, open_load_err[0]};
      5:       obs = {30'h0, out_drive};
      6:       obs = {31'h0, in_state[0]};
      default: obs = {31'h0, save_strobe};
    endcase
  endfunction
  // short mask and save period keep the run brief
  digital_io_channel_supervisor #(.N_IN(2), .N_OUT(2), .CW(32), .INRUSH_US(32'h14),
    .SAVE_US(32'h32)) i_digital_io_channel_supervisor (.clk, .rst, .in_pin,
    .input_filter_time_sel, .input_stretch_time_sel, .in_state, .supply_short_pin,
    .supply_short_supervise_en, .supply_short_err, .inrush_pin, .inrush_mask_en,
    .overcurrent_pin, .load_short_supervise_en, .load_short_restart_mode, .load_short_err,
    .open_load_pin, .open_load_supervise_en, .open_load_err, .out_cmd, .comm_fault,
    .handheld_priority, .comm_fault_output_action, .out_drive, .count_en, .count_limit,
    .count_err, .saved_count, .save_strobe, .count_value);
  dio_field_model i_dio_field_model (.clk, .sensor_on, .supply_fault, .load_shorted, .wire_cut,
    .out_drive, .in_pin, .supply_short_pin, .overcurrent_pin, .open_load_pin, .inrush_pin);
  // ****************
  // tasks and checker
  // ****************
  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task chk(input int idx, input logic [31:0] exp);
    notes.push_back('{idx, exp});
    -> go;
  endtask
  task end_of_test;
    $display("comparisons %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial forever begin
    @go;
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      n_tests++;
      if (obs(nt.idx) !== nt.exp) begin
        errors++;
        $display("[FAIL] %s expected %0h seen %0h", nm[nt.idx], nt.exp, obs(nt.idx));
      end
    end
  end
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      end_of_test;
    end
  end
  initial begin
    seed = 46467;
    {supply_fault, inrush_mask_en, comm_fault, load_short_restart_mode, open_load_supervise_en} = '0;
    {sensor_on, load_shorted, wire_cut, out_cmd, input_filter_time_sel} = '0;
    {input_stretch_time_sel, comm_fault_output_action} = '0;
    {supply_short_supervise_en, load_short_supervise_en, handheld_priority, count_en} = '1;
    count_limit = 16'h0001;
    saved_count = 128'h3E8;
    rst = 1;
    step(10);
    rst = 0;
    step(3);
    chk(0, 32'h3E8);
    chk(1, 32'h0);
    repeat (20) begin
      out_cmd = 2'($random(seed));
      step(1);
      chk(5, {30'h0, out_cmd});
    end
    out_cmd = 2'h0;
    step(1);
    out_cmd = 2'h1;
    step(3);
    chk(1, 32'h1);
    supply_fault = 1;
    step(5);
    chk(2, 32'h1);
    supply_short_supervise_en = 0;
    step(5);
    chk(2, 32'h0);
    wire_cut = 2'h1;
    open_load_supervise_en = 1;
    step(5);
    chk(4, 32'h1);
    for (int m = 0; m < 2; m++) begin
      load_short_restart_mode = m[0];
      load_shorted = 2'h1;
      step(6);
      chk(3, 32'h1);
      load_shorted = 2'h0;
      step(6);
      chk(3, 32'(m));
    end
    rst = 1;
    step(2);
    rst = 0;
    step(3);
    chk(3, 32'h0);
    load_short_restart_mode = 0;
    load_short_supervise_en = 0;
    load_shorted = 2'h1;
    step(6);
    chk(3, 32'h0);
    load_short_supervise_en = 1;
    inrush_mask_en = 1;
    out_cmd = 2'h0;
    step(6);
    out_cmd = 2'h1;
    step(100);
    chk(3, 32'h0);
    step(500);
    chk(3, 32'h1);
    load_shorted = 2'h0;
    for (int a = 0; a < 5; a++) begin
      handheld_priority = (a < 4);
      e = (a == 1 || a == 2) && a < 4;
      out_cmd = {1'b0, a == 1};
      comm_fault_output_action = {2'h0, a == 4 ? 2'h2 : 2'(a)};
      step(6);
      comm_fault = 1;
      step(6);
      // commands opposite to the expected level expose a leak-through
      out_cmd = {1'b0, ~e};
      step(2);
      chk(5, {31'h0, e});
      comm_fault = 0;
    end
    n = 0;
    while (save_strobe !== 1'b1 && n < 1500) begin
      step(1);
      n++;
    end
    chk(7, 32'h1);
    sensor_on = 2'h1;
    step(1000);
    sensor_on = 2'h0;
    step(3000);
    chk(6, 32'h0);
    sensor_on = 2'h1;
    step(3000);
    chk(6, 32'h1);
    sensor_on = 2'h0;
    step(5000);
    chk(6, 32'h1);
    step(25000);
    chk(6, 32'h0);
    step(2);
    end_of_test;
  end
endmodule // testbench
